// [design/fmd_pkg.sv]
package fmd_pkg;
   localparam int unsigned CLK_HZ    = 40_000_000;
   localparam int unsigned MINUTE_S  = 60;
   localparam logic [31:0] MINUTE_CYC = 32'(64'(MINUTE_S) * 64'(CLK_HZ));
   localparam int unsigned HANG_US   = 100;
   localparam logic [11:0] HANG_CYC  = 12'(HANG_US * (CLK_HZ / 1_000_000));
   localparam int unsigned BAUD_BASE = 150;
   localparam int unsigned NUM_LEN   = 23;
   localparam logic [8:0]  A_CTRL = 9'h000;
   localparam logic [8:0]  A_STAT = 9'h004;
   localparam logic [8:0]  A_ADDR = 9'h008;
   localparam logic [8:0]  A_BAUD = 9'h00c;
   localparam logic [8:0]  A_TOUT = 9'h010;
   localparam logic [8:0]  A_REDL = 9'h014;
   localparam logic [8:0]  A_GAP  = 9'h018;
   localparam logic [8:0]  A_INIT = 9'h01c;
   localparam logic [8:0]  A_REP  = 9'h020;
   localparam logic [8:0]  A_FSW  = 9'h024;
   localparam logic [8:0]  A_KEY  = 9'h028;
   localparam logic [1:0]  A_NUM0 = 2'h1;
   localparam logic [1:0]  A_NUM1 = 2'h2;
   localparam int unsigned B_MODEM = 0;
   localparam int unsigned B_TONE  = 1;
   localparam int unsigned B_CLRN  = 2;
   localparam int unsigned B_ALT   = 3;
   localparam int unsigned B_BLK   = 4;
   localparam int unsigned B_A16   = 5;
   localparam logic [9:0]  R_ADDR = 10'h0ff;
   localparam logic [2:0]  R_BAUD = 3'h6;
   localparam logic [6:0]  R_TOUT = 7'h05;
   localparam logic [6:0]  R_REDL = 7'h05;
   localparam logic [7:0]  R_GAP  = 8'h00;
   localparam logic [7:0]  R_INIT = 8'h1e;
   localparam logic [15:0] R_KEY  = 16'h0000;
   localparam logic [9:0]  MAX8   = 10'h0f7;
   localparam logic [9:0]  MAX16  = 10'h3e7;
   localparam logic [6:0]  MAX99  = 7'h63;
   localparam logic [9:0]  KEY_REG = 10'h09e;
   localparam logic [7:0]  CH_DASH = 8'h2d;
   localparam logic [7:0]  CH_P    = 8'h50;
   localparam logic [7:0]  CH_PAUSE = 8'h2c;
   localparam logic [7:0]  CH_CR   = 8'h0d;
   typedef enum logic [2:0] {S_IDLE, S_INIT, S_DIAL, S_WAIT, S_CONN, S_HANG} fmd_state_type;
   typedef struct packed {
      logic       addr_valid;
      logic [9:0] addr;
      logic       rd_fsw;
      logic       wr;
      logic [9:0] wr_reg;
      logic [15:0] wr_data;
   } fmd_stn_type;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } fmd_tx_type;
endpackage : fmd_pkg

// [design/fmd_dialer.sv]
module fmd_dialer #(
   parameter logic [31:0] MIN_CYC = fmd_pkg::MINUTE_CYC,
   parameter int unsigned CLKHZ   = fmd_pkg::CLK_HZ,
   parameter int unsigned NBIN    = 12
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [8:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic [NBIN-1:0]      bin_in,
   input  wire logic                 carrier_in,
   input  wire logic                 busy_in,
   input  wire fmd_pkg::fmd_stn_type stn,
   input  wire logic                 tx_ready,
   output fmd_pkg::fmd_tx_type       modem_tx,
   output logic                      dtr,
   output logic                      baud_tick,
   output logic                      addr_hit,
   output logic                      wr_locked,
   output logic                      wr_ok,
   output logic                      wr_reject
);
   import fmd_pkg::*;

   function automatic logic [7:0] pre_ch(input logic [4:0] i, input logic dial,
                                         input logic tone);
      pre_ch = (i == 5'd0) ? 8'h41 : (i == 5'd1) ? 8'h54 :
               (i == 5'd2) ? (dial ? 8'h44 : 8'h5a) :
               (dial ? (tone ? 8'h54 : 8'h50) : CH_CR);
   endfunction : pre_ch

   function automatic logic [18:0] baud_div(input logic [2:0] code);
      baud_div = 19'(CLKHZ / (BAUD_BASE << code) - 1);
   endfunction : baud_div

   logic                wait_ff;
   logic [31:0]         rdata_ff;
   logic [5:0]          ctrl_ff;
   logic [9:0]          addr_ff;
   logic [2:0]          baud_ff;
   logic [6:0]          tout_ff;
   logic [6:0]          redl_ff;
   logic [7:0]          gap_ff;
   logic [7:0]          init_ff;
   logic [NBIN-1:0]     rep_ff;
   logic [15:0]         key_ff;
   logic [7:0]          num_mem [2][NUM_LEN];
   logic [NBIN+1:0]     s1_ff;
   logic [NBIN+1:0]     s2_ff;
   logic [NBIN-1:0]     fsw_ff;
   logic [NBIN-1:0]     old_ff;
   fmd_state_type       state_ff;
   fmd_state_type       nxt_state;
   logic [4:0]          idx_ff;
   logic [4:0]          nxt_idx;
   fmd_tx_type          tx_ff;
   fmd_tx_type          nxt_tx;
   logic [31:0]         pre_ff;
   logic [6:0]          min_ff;
   logic [7:0]          gapc_ff;
   logic [7:0]          initc_ff;
   logic [11:0]         hang_ff;
   logic [6:0]          att_ff;
   logic                alt_ff;
   logic                req_ff;
   logic                ans_ff;
   logic                lock_ff;
   logic [18:0]         bcnt_ff;
   logic                btick_ff;
   logic                hit_ff;
   logic                wok_ff;
   logic                wrej_ff;
   logic                dtr_ff;

   // Pin levels, after two flops
   wire [NBIN-1:0] bin_s   = s2_ff[NBIN-1:0];
   wire            carrier = s2_ff[NBIN];
   wire            busy    = s2_ff[NBIN+1];

   // Bus decode
   wire        req      = avs_read | avs_write;
   wire        wr_acc   = avs_write & ~wait_ff;
   wire [31:0] wd       = avs_writedata;
   wire        num_hit  = (avs_address[8:7] == A_NUM0 || avs_address[8:7] == A_NUM1) &&
                          avs_address[6:2] < 5'(NUM_LEN);
   wire        num_sel  = avs_address[8];
   wire [4:0]  num_ix   = avs_address[6:2];
   wire        a16      = ctrl_ff[B_A16];
   wire        modem_en = ctrl_ff[B_MODEM];
   wire        blk      = ctrl_ff[B_BLK];
   wire [9:0]  addr_lim = a16 ? MAX16 : MAX8;
   wire [31:0] stat_w   = {17'h0, att_ff, carrier, ans_ff, lock_ff, alt_ff, req_ff,
                           3'(state_ff)};
   wire [31:0] rd_mux   =
      num_hit                 ? {24'h0, num_mem[num_sel][num_ix]} :
      avs_address == A_CTRL   ? {26'h0, ctrl_ff} :
      avs_address == A_STAT   ? stat_w :
      avs_address == A_ADDR   ? {22'h0, addr_ff} :
      avs_address == A_BAUD   ? {29'h0, baud_ff} :
      avs_address == A_TOUT   ? {25'h0, tout_ff} :
      avs_address == A_REDL   ? {25'h0, redl_ff} :
      avs_address == A_GAP    ? {24'h0, gap_ff} :
      avs_address == A_INIT   ? {24'h0, init_ff} :
      avs_address == A_REP    ? 32'(rep_ff) :
      avs_address == A_FSW    ? 32'(fsw_ff) :
      avs_address == A_KEY    ? {16'h0, key_ff} : 32'h0;

   // Fault word events
   wire [NBIN-1:0] rise    = fsw_ff & ~old_ff;
   wire [NBIN-1:0] fall    = ~fsw_ff & old_ff;
   wire call_ev  = modem_en & ~blk & ((|rise) | (ctrl_ff[B_CLRN] & (|fall)));
   wire call_clr = stn.rd_fsw & (state_ff == S_CONN);

   // Timers
   wire min_tick = pre_ff == MIN_CYC - 32'd1;
   wire tmo      = min_ff >= tout_ff;
   wire gap_ok   = gapc_ff >= gap_ff;
   wire dial_go  = state_ff == S_IDLE && req_ff && modem_en && !blk && gap_ok;
   wire init_go  = state_ff == S_IDLE && modem_en && init_ff != 8'h0 &&
                   initc_ff >= init_ff && !dial_go;
   wire fail     = state_ff == S_WAIT && !carrier && (busy || tmo);
   wire last_try = 7'(att_ff + 7'd1) >= redl_ff;

   // Character generation
   wire [4:0] nix   = 5'(idx_ff - 5'd4);
   wire       nin   = nix < 5'(NUM_LEN);
   wire [7:0] nch   = nin ? num_mem[alt_ff][nix] : CH_DASH;
   wire       nend  = nch == CH_DASH;
   wire       is_pre = state_ff == S_INIT || idx_ff < 5'd4;
   wire [7:0] cur_ch = is_pre ? pre_ch(idx_ff, state_ff == S_DIAL, ctrl_ff[B_TONE]) :
                       nend ? CH_CR : (nch == CH_P ? CH_PAUSE : nch);
   wire       last_ch = is_pre ? (state_ff == S_INIT && idx_ff == 5'd3) : nend;

   // Station side
   wire [9:0] own    = a16 ? addr_ff : {2'h0, addr_ff[7:0]};
   wire       hit_w  = stn.addr_valid && stn.addr == own;
   wire       key_ok = stn.wr && stn.wr_reg == KEY_REG && stn.wr_data == key_ff;
   wire       conn_go = state_ff == S_WAIT && carrier;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_idx   = idx_ff;
      nxt_tx    = tx_ff;
      case (state_ff)
         S_IDLE:
         begin
            nxt_idx = 5'd0;
            if (dial_go)
               nxt_state = S_DIAL;
            else if (init_go)
               nxt_state = S_INIT;
         end
         S_INIT, S_DIAL:
         begin
            // Index held while a char waits, so last_ch stays stable
            if (!tx_ff.valid)
               nxt_tx = '{valid: 1'b1, data: cur_ch};
            else if (tx_ready)
            begin
               nxt_tx.valid = 1'b0;
               if (last_ch)
                  nxt_state = (state_ff == S_DIAL) ? S_WAIT : S_IDLE;
               else
                  nxt_idx = 5'(idx_ff + 5'd1);
            end
         end
         S_WAIT:
         begin
            if (carrier)
               nxt_state = S_CONN;
            else if (fail)
               nxt_state = S_HANG;
         end
         S_CONN:
         begin
            if (!carrier || (!ans_ff && tmo))
               nxt_state = S_HANG;
         end
         S_HANG:
         begin
            if (hang_ff == HANG_CYC)
               nxt_state = S_IDLE;
         end
         default:
            nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0;
         ctrl_ff  <= 6'h0;
         addr_ff  <= R_ADDR;
         baud_ff  <= R_BAUD;
         tout_ff  <= R_TOUT;
         redl_ff  <= R_REDL;
         gap_ff   <= R_GAP;
         init_ff  <= R_INIT;
         rep_ff   <= '0;
         key_ff   <= R_KEY;
      end
      else
      begin
         wait_ff <= ~(req & wait_ff);
         if (req & wait_ff)
            rdata_ff <= rd_mux;
         if (wr_acc)
         begin
            if (avs_address == A_CTRL)
               ctrl_ff <= wd[5:0];
            if (avs_address == A_ADDR && wd[9:0] <= addr_lim && wd[31:10] == 22'h0)
               addr_ff <= wd[9:0];
            if (avs_address == A_BAUD && wd[2:0] <= R_BAUD)
               baud_ff <= wd[2:0];
            if (avs_address == A_TOUT && wd[6:0] <= MAX99)
               tout_ff <= wd[6:0];
            if (avs_address == A_REDL && wd[6:0] <= MAX99)
               redl_ff <= wd[6:0];
            if (avs_address == A_GAP)
               gap_ff <= wd[7:0];
            if (avs_address == A_INIT)
               init_ff <= wd[7:0];
            if (avs_address == A_REP)
               rep_ff <= wd[NBIN-1:0];
            if (avs_address == A_KEY)
               key_ff <= wd[15:0];
         end
      end
   end

   // Number store has no reset; software loads it before enabling the modem
   always_ff @(posedge clk)
   begin
      if (wr_acc && num_hit)
         num_mem[num_sel][num_ix] <= wd[7:0];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_ff  <= '0;
         s2_ff  <= '0;
         fsw_ff <= '0;
         old_ff <= '0;
         req_ff <= 1'b0;
      end
      else
      begin
         s1_ff  <= {busy_in, carrier_in, bin_in};
         s2_ff  <= s1_ff;
         fsw_ff <= bin_s & rep_ff;
         old_ff <= fsw_ff;
         req_ff <= call_ev | (req_ff & ~call_clr);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_ff <= S_IDLE;
         idx_ff   <= 5'd0;
         tx_ff    <= '0;
         hang_ff  <= 12'h0;
         dtr_ff   <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         idx_ff   <= nxt_idx;
         tx_ff    <= nxt_tx;
         hang_ff  <= (state_ff == S_HANG) ? 12'(hang_ff + 12'd1) : 12'h0;
         dtr_ff   <= nxt_state != S_HANG;
      end
   end

   // Minute prescaler; coarse one-minute resolution keeps counters small
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pre_ff   <= 32'h0;
         min_ff   <= 7'h0;
         gapc_ff  <= 8'hff;
         initc_ff <= 8'h0;
      end
      else
      begin
         pre_ff <= min_tick ? 32'h0 : 32'(pre_ff + 32'd1);
         if (nxt_state != state_ff)
            min_ff <= 7'h0;
         else if (min_tick && min_ff != 7'h7f)
            min_ff <= 7'(min_ff + 7'd1);
         if (dial_go)
            gapc_ff <= 8'h0;
         else if (min_tick && gapc_ff != 8'hff)
            gapc_ff <= 8'(gapc_ff + 8'd1);
         if (state_ff != S_IDLE || init_go)
            initc_ff <= 8'h0;
         else if (min_tick && initc_ff != 8'hff)
            initc_ff <= 8'(initc_ff + 8'd1);
      end
   end

   // Attempt bookkeeping; a call only ends at connect, the request may outlive it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         att_ff <= 7'h0;
         alt_ff <= 1'b0;
      end
      else if (conn_go)
      begin
         att_ff <= 7'h0;
         alt_ff <= 1'b0;
      end
      else if (fail)
      begin
         if (last_try)
         begin
            att_ff <= 7'h0;
            alt_ff <= ctrl_ff[B_ALT] & ~alt_ff;
         end
         else
            att_ff <= 7'(att_ff + 7'd1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ans_ff   <= 1'b0;
         lock_ff  <= 1'b0;
         hit_ff   <= 1'b0;
         wok_ff   <= 1'b0;
         wrej_ff  <= 1'b0;
         bcnt_ff  <= 19'h0;
         btick_ff <= 1'b0;
      end
      else
      begin
         ans_ff  <= (state_ff == S_CONN) & (ans_ff | hit_w);
         lock_ff <= conn_go | (lock_ff & ~key_ok);
         hit_ff  <= hit_w;
         wok_ff  <= stn.wr & (~lock_ff | key_ok);
         wrej_ff <= stn.wr & lock_ff & ~key_ok;
         btick_ff <= bcnt_ff == 19'h0;
         bcnt_ff <= (bcnt_ff == 19'h0) ? baud_div(baud_ff) : 19'(bcnt_ff - 19'd1);
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign modem_tx        = tx_ff;
   assign dtr             = dtr_ff;
   assign baud_tick       = btick_ff;
   assign addr_hit        = hit_ff;
   assign wr_locked       = lock_ff;
   assign wr_ok           = wok_ff;
   assign wr_reject       = wrej_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_call_raise: assert property (call_ev |=> req_ff)
      else $error("Fault change did not raise call");
   chk_req_hold: assert property (req_ff && !call_clr |=> req_ff)
      else $error("Call request lost early");
   chk_give_up: assert property (state_ff == S_CONN && !ans_ff && tmo |=> state_ff == S_HANG)
      else $error("Unanswered link not dropped");
   chk_dial_block: assert property (blk && state_ff == S_IDLE |=> state_ff != S_DIAL)
      else $error("Dial while blocked");
   chk_clear_call: assert property ($fell(|fsw_ff) && ctrl_ff[B_CLRN] && modem_en && !blk
                                    |=> req_ff)
      else $error("Cleared fault not reported");
   chk_alt_switch: assert property (fail && last_try && ctrl_ff[B_ALT] && !alt_ff |=> alt_ff)
      else $error("No switch to alternate number");
   chk_gap_keep: assert property (state_ff == S_IDLE && !gap_ok |=> state_ff != S_DIAL)
      else $error("Call gap broken");
   chk_no_init: assert property (state_ff inside {S_DIAL, S_WAIT, S_CONN}
                                 |=> state_ff != S_INIT)
      else $error("Modem reset during call");
   chk_key_lock: assert property (conn_go ##1 stn.wr && !key_ok |=> wr_reject)
      else $error("Write taken while locked");

   cov_connect: cover property (state_ff == S_WAIT ##1 state_ff == S_CONN);
   cov_alt_used: cover property (!alt_ff ##1 alt_ff);
   cov_init_sent: cover property (state_ff == S_INIT ##1 state_ff == S_IDLE);
   cov_unlock: cover property (lock_ff ##1 !lock_ff);
endmodule : fmd_dialer

// [sim/fmd_modem_model.sv]
module fmd_modem_model
   import fmd_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire fmd_pkg::fmd_tx_type modem_tx,
   input  wire logic                dtr,
   input  wire logic [1:0]          mode,
   input  wire logic                drop,
   output logic                     tx_ready,
   output logic                     carrier_in,
   output logic                     busy_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Mode 0 answers, 1 busy once then answers, 2 stays silent
   logic [7:0] c1_ff;
   logic [7:0] c2_ff;
   logic       dial_ff;
   logic       busy_once_ff;
   int         wait_cnt;
   always @(posedge clk)
   begin
      // Random stalls so the held character is exercised
      tx_ready <= ($urandom_range(3) != 0);
      if (!rst_n)
      begin
         c1_ff <= 8'h00;
         c2_ff <= 8'h00;
         dial_ff <= 1'b0;
         busy_once_ff <= 1'b0;
         wait_cnt <= 0;
         carrier_in <= 1'b0;
         busy_in <= 1'b0;
      end
      else
      begin
         if (modem_tx.valid && tx_ready)
         begin
            c2_ff <= c1_ff;
            c1_ff <= modem_tx.data;
            if (c2_ff == 8'h41 && c1_ff == 8'h54 && modem_tx.data == 8'h44)
               dial_ff <= 1'b1;
            if (modem_tx.data == CH_CR && dial_ff)
            begin
               dial_ff <= 1'b0;
               wait_cnt <= 20;
            end
         end
         if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
         if (wait_cnt == 1 && mode == 2'h1 && !busy_once_ff)
         begin
            busy_in <= 1'b1;
            busy_once_ff <= 1'b1;
         end
         else if (wait_cnt == 1 && mode != 2'h2)
            carrier_in <= 1'b1;
         // Line released on hang-up, so no stale carrier or busy
         if (!dtr || drop)
         begin
            carrier_in <= 1'b0;
            busy_in <= 1'b0;
         end
      end
   end
endmodule : fmd_modem_model

// [sim/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fmd_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m;} fmd_rdexp_type;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [8:0]        avs_address = 9'h000;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [31:0]       avs_writedata = 32'h0;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   logic [11:0]       bin_in = 12'h000;
   logic              carrier_in;
   logic              busy_in;
   fmd_stn_type       stn = '0;
   logic              tx_ready;
   fmd_tx_type        modem_tx;
   logic              dtr;
   logic              baud_tick;
   logic              addr_hit;
   logic              wr_locked;
   logic              wr_ok;
   logic              wr_reject;
   logic [1:0]        mode = 2'h0;
   logic              drop = 1'b0;
   logic              stn_pend = 1'b0;
   fmd_rdexp_type     rd_e;
   fmd_rdexp_type     rd_q[$];
   logic [7:0]        tx_q[$];
   logic [2:0]        stn_q[$];
   int                err_total = 0;
   int                n_checks = 0;
   int                n;
   logic [8:0]        ra[8] = '{A_CTRL, A_ADDR, A_BAUD, A_TOUT, A_REDL, A_GAP, A_INIT, A_KEY};
   logic [31:0]       rv[8] = '{32'h0, 32'h0ff, 32'h6, 32'h5, 32'h5, 32'h0, 32'h01e, 32'h0};
   always #12.5 clk = ~clk;
   fmd_dialer #(.MIN_CYC(32'h64), .CLKHZ(153_600), .NBIN(12)) u_dut (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .bin_in(bin_in), .carrier_in(carrier_in),
      .busy_in(busy_in), .stn(stn), .tx_ready(tx_ready), .modem_tx(modem_tx), .dtr(dtr),
      .baud_tick(baud_tick), .addr_hit(addr_hit), .wr_locked(wr_locked), .wr_ok(wr_ok),
      .wr_reject(wr_reject));
   fmd_modem_model u_modem (.clk(clk), .rst_n(rst_n), .modem_tx(modem_tx), .dtr(dtr),
      .mode(mode), .drop(drop), .tx_ready(tx_ready), .carrier_in(carrier_in),
      .busy_in(busy_in));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   // Results are matched in order against what the drivers queued
   always @(posedge clk)
   begin
      if (avs_read && !avs_waitrequest && rd_q.size() > 0)
      begin
         rd_e = rd_q.pop_front();
         check("readdata", avs_readdata & rd_e.m, rd_e.v);
      end
      if (modem_tx.valid && tx_ready && tx_q.size() == 0)
         check("tx_extra", {24'h0, modem_tx.data}, 32'h100);
      else if (modem_tx.valid && tx_ready)
         check("tx_char", {24'h0, modem_tx.data}, {24'h0, tx_q.pop_front()});
      if (stn_pend)
         check("stn_reply", {29'h0, addr_hit, wr_ok, wr_reject}, {29'h0, stn_q.pop_front()});
      stn_pend <= stn.addr_valid | stn.wr | stn.rd_fsw;
   end
   task automatic bus(input logic rd, input logic [8:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && k < 100)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 100)
         check("bus_wait", 32'h1, 32'h0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      rd_q.push_back('{e & m, m});
      bus(1'b1, a, 32'h0);
   endtask : rd
   task automatic exp_text(input string s);
      foreach (s[i]) tx_q.push_back(s[i]);
   endtask : exp_text
   task automatic wait_tx(input int lim);
      int k;
      k = 0;
      while (tx_q.size() > 0 && k < lim)
      begin
         @(posedge clk);
         k++;
      end
      check("tx_drain", 32'(tx_q.size()), 32'h0);
   endtask : wait_tx
   task automatic wait_sig(input logic which, input logic v, input int lim);
      n = 0;
      @(posedge clk);
      while ((which ? wr_locked : dtr) !== v && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      check("level", {31'h0, which ? wr_locked : dtr}, {31'h0, v});
   endtask : wait_sig
   task automatic stn_send(input fmd_stn_type v, input logic [2:0] e);
      @(posedge clk);
      stn <= v;
      stn_q.push_back(e);
      @(posedge clk);
      stn <= '0;
   endtask : stn_send
   task automatic tick_gap(input logic [31:0] e);
      repeat (2)
      begin
         n = 0;
         @(posedge clk);
         while (!baud_tick && n < 3000)
         begin
            @(posedge clk);
            n++;
         end
      end
      check("baud_gap", 32'(n + 1), e);
   endtask : tick_gap
   task automatic connect_clear(input logic [15:0] key);
      wait_sig(1'b1, 1'b1, 300);
      stn_send('{1'b1, 10'h0c8, 1'b0, 1'b0, 10'h0, 16'h0}, 3'b100);
      stn_send('{1'b0, 10'h0, 1'b0, 1'b1, 10'h005, 16'($urandom)}, 3'b001);
      stn_send('{1'b0, 10'h0, 1'b0, 1'b1, 10'h09e, key}, 3'b010);
      stn_send('{1'b0, 10'h0, 1'b0, 1'b1, 10'h005, 16'h0001}, 3'b010);
      stn_send('{1'b1, 10'h0c9, 1'b0, 1'b0, 10'h0, 16'h0}, 3'b000);
      rd(A_STAT, 32'h8, 32'h8);
      stn_send('{1'b0, 10'h0, 1'b1, 1'b0, 10'h0, 16'h0}, 3'b000);
      rd(A_STAT, 32'h0, 32'h8);
      drop <= 1'b1;
      wait_sig(1'b0, 1'b0, 100);
      wait_sig(1'b0, 1'b1, 5000);
      drop <= 1'b0;
   endtask : connect_clear
   initial
   begin
      repeat (90000) @(posedge clk);
      err_total++;
      stop_test();
   end
   initial
   begin
      void'($urandom(64935));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ra[i]) rd(ra[i], rv[i]);
      // Periodic init off until its own scenario, so no stray text
      wr(A_INIT, 32'h0);
      wr(9'h03c, $urandom);
      rd(9'h03c, 32'h0);
      wr(A_ADDR, 32'h0f8);
      rd(A_ADDR, 32'h0ff);
      wr(A_ADDR, 32'h0f7);
      rd(A_ADDR, 32'h0f7);
      wr(A_CTRL, 32'h020);
      wr(A_ADDR, 32'h3e8);
      rd(A_ADDR, 32'h0f7);
      wr(A_ADDR, 32'h3e7);
      rd(A_ADDR, 32'h3e7);
      wr(A_ADDR, 32'h0c8);
      wr(A_TOUT, 32'h064);
      rd(A_TOUT, 32'h5);
      tick_gap(32'd16);
      wr(A_BAUD, 32'h0);
      tick_gap(32'd1024);
      wr(A_BAUD, 32'h6);
      exp_text("12P3-9");
      foreach (tx_q[i]) wr(9'h080 + 9'(4 * i), {24'h0, tx_q[i]});
      tx_q.delete();
      wr(9'h100, 32'h37);
      wr(9'h104, 32'h2d);
      wr(A_REP, 32'h00f);
      wr(A_REDL, 32'h1);
      wr(A_CTRL, 32'h001);
      bin_in <= 12'h001;
      exp_text("ATDP12,3\r");
      wait_tx(2000);
      connect_clear(16'h0);
      wr(A_KEY, 32'h1234);
      wr(A_CTRL, 32'h00b);
      mode <= 2'h1;
      bin_in <= 12'h003;
      exp_text("ATDT12,3\rATDT7\r");
      wait_tx(9000);
      connect_clear(16'h1234);
      wr(A_TOUT, 32'h1);
      wr(A_CTRL, 32'h001);
      mode <= 2'h2;
      bin_in <= 12'h007;
      exp_text("ATDP12,3\r");
      wait_tx(2000);
      wait_sig(1'b0, 1'b0, 400);
      check("giveup", {31'h0, n <= 110}, 32'h1);
      // Long give-up again, so the station has time to address the unit
      wr(A_TOUT, 32'h5);
      mode <= 2'h0;
      exp_text("ATDP12,3\r");
      wait_tx(6000);
      connect_clear(16'h1234);
      wr(A_CTRL, 32'h005);
      bin_in <= 12'h000;
      exp_text("ATDP12,3\r");
      wait_tx(2000);
      connect_clear(16'h1234);
      wr(A_CTRL, 32'h011);
      bin_in <= 12'h00f;
      repeat (300) @(posedge clk);
      rd(A_STAT, 32'h0, 32'h7);
      wr(A_INIT, 32'h1);
      exp_text("ATZ\r");
      wait_tx(400);
      stop_test();
   end
endmodule : tb_top
